// >>> include/cit_pkg.sv
// Constants for the current interrupter timing block.
// Assumes a 100 MHz ref_clk; times are converted to cycles here.
package cit_pkg;
  // ==========================================================
  // Timing
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned MS_PER_S = 1000;
  localparam int unsigned CYC_PER_MS = CLK_HZ / MS_PER_S;
  localparam int unsigned CYCLE_MS = 1000;
  // ==========================================================
  // Setting ranges
  localparam logic [5:0] SEC_MIN = 6'h01;
  localparam logic [5:0] SEC_MAX = 6'h3C;
  localparam logic [9:0] ON_MS_MIN = 10'h0C8;
  localparam logic [9:0] ON_MS_MAX = 10'h320;
  localparam logic [9:0] CYCLE_MS_W = 10'h3E8;
  // ==========================================================
  // Calendar stamp layout: year, month, day, hour, minute
  localparam int STAMP_W = 27;
  localparam int YEAR_LSB = 20;
  localparam int MONTH_LSB = 16;
  localparam int DAY_LSB = 11;
  localparam int HOUR_LSB = 6;
  localparam int MIN_LSB = 0;
  // ==========================================================
  // Modes
  typedef enum logic {CIT_MODE_INT = 1'b0, CIT_MODE_EXT = 1'b1} cit_mode_e;
endpackage : cit_pkg

// >>> rtl/cit_ms_tick.sv
// Millisecond tick generator for the interrupter timing block.
// Assumes ref_clk at the rate given in the package.
`timescale 1ns/10ps
`default_nettype none
module cit_ms_tick #(
  parameter int unsigned DIV = cit_pkg::CYC_PER_MS
) (
  // Clock and control
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  // Tick
  output logic ms_tick
);
  import cit_pkg::*;
  typedef struct packed {
    logic [16:0] cnt;
    logic tick;
  } cit_tk_s;
  cit_tk_s st, next_st;
  always_comb begin
    next_st = st;
    next_st.tick = 1'b0;
    if (st.cnt == 17'(DIV - 1)) begin
      next_st.cnt = '0;
      next_st.tick = 1'b1;
    end else begin
      next_st.cnt = st.cnt + 17'h00001;
    end
  end
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      st <= '0;
    end else if (clk_en) begin
      st <= next_st;
    end
  end
  assign ms_tick = st.tick;
endmodule : cit_ms_tick
`default_nettype wire

// >>> rtl/cit_core.sv
// Current interrupter timing: internal on/off cycling inside a calendar
// window, or mirroring of an external interrupter contact.
// Assumes inputs synchronous to ref_clk and a calendar stamp supplied
// by the time source, advancing monotonically.
//
// Operation
// - Mode input picks internal or external switching source.
// - Internal mode cycles on/off intervals only between start and stop stamps.
// - External mode enters running state at once, no start wait.
// - External mode output tracks the external contact input.
// - Run indicator lit while running with interrupter closed, dark while open or stopped.
// - Seconds range: independent on and off intervals of 1 to 60 s.
// - Start and stop stamps only gate cycling in internal mode; error flag checks them in both.
// - Stamps hold hour, minute, day, month and year fields.
// - Error flag raised when stop stamp not later than start stamp.
`timescale 1ns/10ps
`default_nettype none
module cit_core #(
  parameter int unsigned MS_DIV = cit_pkg::CYC_PER_MS
) (
  // Clock, reset, enable
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  // Settings
  input wire cit_pkg::cit_mode_e mode,
  input wire logic ms_range,
  input wire logic [5:0] on_sec,
  input wire logic [5:0] off_sec,
  input wire logic [9:0] on_ms,
  input wire logic [cit_pkg::STAMP_W-1:0] start_stamp,
  input wire logic [cit_pkg::STAMP_W-1:0] stop_stamp,
  input wire logic [cit_pkg::STAMP_W-1:0] now_stamp,
  // External contact, high when closed
  input wire logic ext_closed,
  // Outputs
  output logic intr_closed,
  output logic run_led,
  output logic running,
  output logic window_err
);
  import cit_pkg::*;

  // ==========================================================
  // Helpers
  function automatic logic [5:0] clip_sec(input logic [5:0] v);
    if (v < SEC_MIN) begin
      return SEC_MIN;
    end else if (v > SEC_MAX) begin
      return SEC_MAX;
    end
    return v;
  endfunction : clip_sec

  function automatic logic [STAMP_W-1:0] stamp_key(input logic [STAMP_W-1:0] s);
    // Fields already run year down to minute, so a plain compare is chronological
    return {s[YEAR_LSB +: 7], s[MONTH_LSB +: 4], s[DAY_LSB +: 5], s[HOUR_LSB +: 5], s[MIN_LSB +: 6]};
  endfunction : stamp_key

  // ==========================================================
  // State
  typedef enum logic [1:0] {CIT_PH_ON = 2'b01, CIT_PH_OFF = 2'b10} cit_ph_e;
  typedef struct packed {
    cit_ph_e ph;
    logic [9:0] ms_cnt;
    logic [5:0] sec_cnt;
    logic closed;
    logic run;
    logic err;
    logic led;
  } cit_core_s;
  cit_core_s st, next_st;

  logic tick;
  logic [STAMP_W-1:0] k_start, k_stop, k_now;
  logic in_win, seg_end;
  logic [9:0] on_ms_c, seg_ms;
  logic [5:0] seg_sec;

  cit_ms_tick #(.DIV(MS_DIV)) u_tick (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .clk_en(clk_en),
    .ms_tick(tick)
  );

  // ==========================================================
  // Window and segment lengths
  always_comb begin
    k_start = stamp_key(start_stamp);
    k_stop = stamp_key(stop_stamp);
    k_now = stamp_key(now_stamp);
    in_win = (k_now >= k_start) && (k_now < k_stop);
    on_ms_c = (on_ms < ON_MS_MIN) ? ON_MS_MIN : ((on_ms > ON_MS_MAX) ? ON_MS_MAX : on_ms);
    seg_sec = (st.ph == CIT_PH_ON) ? clip_sec(on_sec) : clip_sec(off_sec);
    seg_ms = (st.ph == CIT_PH_ON) ? on_ms_c : (CYCLE_MS_W - on_ms_c);
    // Not equal but at-or-past: a setting lowered mid-segment ends it
    // at the next tick, or at the end of the current second in seconds range, instead of letting the counter wrap
    if (ms_range) begin
      seg_end = (st.ms_cnt >= seg_ms - 10'h001);
    end else begin
      seg_end = (st.ms_cnt == 10'(MS_PER_S - 1)) && (st.sec_cnt >= seg_sec - 6'h01);
    end
  end

  // ==========================================================
  // Next state
  always_comb begin
    next_st = st;
    next_st.err = (k_stop <= k_start);
    if (mode == CIT_MODE_EXT) begin
      // Start and stop ignored; contact mirrored straight through
      next_st.run = 1'b1;
      next_st.closed = ext_closed;
      next_st.ph = CIT_PH_ON;
      next_st.ms_cnt = '0;
      next_st.sec_cnt = '0;
    end else if (!in_win || st.err) begin
      next_st.run = 1'b0;
      next_st.closed = 1'b1;
      next_st.ph = CIT_PH_ON;
      next_st.ms_cnt = '0;
      next_st.sec_cnt = '0;
    end else begin
      next_st.run = 1'b1;
      next_st.closed = (st.ph == CIT_PH_ON);
      if (tick) begin
        if (seg_end) begin
          next_st.ms_cnt = '0;
          next_st.sec_cnt = '0;
          unique case (st.ph)
            CIT_PH_ON: next_st.ph = CIT_PH_OFF;
            CIT_PH_OFF: next_st.ph = CIT_PH_ON;
            default: next_st.ph = CIT_PH_ON;
          endcase
        end else if (!ms_range && st.ms_cnt == 10'(MS_PER_S - 1)) begin
          next_st.ms_cnt = '0;
          next_st.sec_cnt = st.sec_cnt + 6'h01;
        end else begin
          next_st.ms_cnt = st.ms_cnt + 10'h001;
        end
      end
    end
    // Indicator has its own flop so the pin comes glitch free
    next_st.led = next_st.closed && next_st.run;
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      st <= '{
        ph: CIT_PH_ON,
        ms_cnt: '0,
        sec_cnt: '0,
        closed: 1'b1,
        run: 1'b0,
        err: 1'b0,
        led: 1'b0
      };
    end else if (clk_en) begin
      st <= next_st;
    end
  end

  assign intr_closed = st.closed;
  assign run_led = st.led;
  assign running = st.run;
  assign window_err = st.err;

  // ==========================================================
  // Checks
  a_ext_tracks: assert property (@(posedge ref_clk) disable iff (sys_rst)
    clk_en && mode == CIT_MODE_EXT |=> intr_closed == $past(ext_closed))
    else $error("closed state does not follow external contact");

  a_ext_runs: assert property (@(posedge ref_clk) disable iff (sys_rst)
    clk_en && mode == CIT_MODE_EXT |=> running)
    else $error("external mode not running");

  a_ext_no_wait: assert property (@(posedge ref_clk) disable iff (sys_rst)
    clk_en && mode == CIT_MODE_EXT && !in_win |=> running)
    else $error("external mode waits for window");

  a_led_ext: assert property (@(posedge ref_clk) disable iff (sys_rst)
    clk_en && mode == CIT_MODE_EXT |=> run_led == $past(ext_closed))
    else $error("run indicator does not follow external contact");

  a_err_flag: assert property (@(posedge ref_clk) disable iff (sys_rst)
    clk_en |=> window_err == $past(stamp_key(stop_stamp) <= stamp_key(start_stamp)))
    else $error("window error flag wrong");

  a_err_held: assert property (@(posedge ref_clk) disable iff (sys_rst)
    clk_en && mode == CIT_MODE_INT && window_err |=> intr_closed && !running)
    else $error("cycling with bad window setting");

  a_out_win_on: assert property (@(posedge ref_clk) disable iff (sys_rst)
    clk_en && mode == CIT_MODE_INT && !in_win |=> intr_closed && !running)
    else $error("output not held on outside window");

  a_led_match: assert property (@(posedge ref_clk) disable iff (sys_rst)
    running |-> run_led == intr_closed)
    else $error("run indicator disagrees with interrupter");

  a_led_dark: assert property (@(posedge ref_clk) disable iff (sys_rst)
    !running |-> !run_led)
    else $error("run indicator lit while stopped");

  // Counters stay inside their ranges even when settings move mid-segment
  a_ms_bound: assert property (@(posedge ref_clk) disable iff (sys_rst)
    ms_range && mode == CIT_MODE_INT |-> st.ms_cnt < CYCLE_MS_W)
    else $error("millisecond count exceeds cycle");

  a_sec_bound: assert property (@(posedge ref_clk) disable iff (sys_rst)
    !ms_range && mode == CIT_MODE_INT |-> st.sec_cnt < SEC_MAX)
    else $error("second count exceeds limit");

  a_ph_legal: assert property (@(posedge ref_clk) disable iff (sys_rst)
    $onehot(st.ph))
    else $error("phase state not one-hot");

  a_in_win_run: assert property (@(posedge ref_clk) disable iff (sys_rst)
    clk_en && mode == CIT_MODE_INT && in_win && !window_err |=> running)
    else $error("not running inside window");
endmodule : cit_core
`default_nettype wire

// >>> verif/cit_contact_model.sv
// Model of the outside interrupter contact.
// Assumes want_closed is driven by the bench just after ref_clk edges.
`timescale 1ns/10ps
`default_nettype none
module cit_contact_model (
  // Clock
  input wire logic ref_clk,
  // Commanded interrupter state
  input wire logic want_closed,
  // Contact, high when closed
  output logic ext_closed
);
  initial ext_closed = 1'b0;
  // One cycle of contact settling, old level shown until the next edge
  always @(posedge ref_clk) begin
    ext_closed <= want_closed;
  end
endmodule : cit_contact_model
`default_nettype wire

// >>> verif/tb_top.sv
// Self-checking bench for cit_core with random settings and corner cases.
// Assumes MS_DIV of 10, so one millisecond is 10 ref_clk cycles.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import cit_pkg::*;
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic clk_en = 1'b1;
  cit_mode_e mode = CIT_MODE_INT;
  logic ms_range = 1'b1;
  logic [5:0] on_sec = 6'h01;
  logic [5:0] off_sec = 6'h02;
  logic [9:0] on_ms = 10'h0C8;
  logic [STAMP_W-1:0] start_stamp = 27'h0000100;
  logic [STAMP_W-1:0] stop_stamp = 27'h0000200;
  logic [STAMP_W-1:0] now_stamp = 27'h0000150;
  logic want_closed = 1'b0;
  logic ext_closed, intr_closed, run_led, running, window_err;
  int err_count = 0;
  int cmp_count = 0;
  int n;
  int len;
  cit_core #(.MS_DIV(10)) dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .clk_en(clk_en), .mode(mode),
    .ms_range(ms_range), .on_sec(on_sec), .off_sec(off_sec), .on_ms(on_ms), .start_stamp(start_stamp),
    .stop_stamp(stop_stamp), .now_stamp(now_stamp), .ext_closed(ext_closed), .intr_closed(intr_closed),
    .run_led(run_led), .running(running), .window_err(window_err));
  cit_contact_model u_contact (.ref_clk(ref_clk), .want_closed(want_closed), .ext_closed(ext_closed));
  initial begin
    forever #5 ref_clk = ~ref_clk;
  end
  // ==========================================================
  // Helpers
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic step(input int k);
    repeat (k) @(posedge ref_clk);
    #1;
  endtask : step
  task automatic run_len(input logic v, output int l);
    for (l = 0; l < 40000 && intr_closed === v; l++) step(1);
  endtask : run_len
  // Measured segments start on a phase change, so lengths are exact
  task automatic chk_len(input int got, input int exp);
    chk(32'(got), 32'(exp));
  endtask : chk_len
  task automatic cycle_chk(input int on_c, input int off_c);
    run_len(1'b1, len);
    run_len(1'b0, len);
    run_len(1'b1, len);
    chk_len(len, on_c);
    run_len(1'b0, len);
    chk_len(len, off_c);
    chk({running, intr_closed, run_led}, 3'h7);
  endtask : cycle_chk
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : summarize
  // ==========================================================
  // Tests
  initial begin
    void'($urandom(84));
    step(4);
    chk({intr_closed, running, run_led, window_err}, 4'h8);
    sys_rst = 1'b0;
    $display("test reset done");
    mode = CIT_MODE_EXT;
    now_stamp = 27'h0000300;
    for (n = 0; n < 12; n++) begin
      want_closed = (n < 2) ? n[0] : 1'($urandom);
      step(3);
      chk({running, intr_closed, run_led}, {1'b1, want_closed, want_closed});
    end
    $display("test external done");
    mode = CIT_MODE_INT;
    step(3);
    chk({window_err, running, intr_closed, run_led}, 4'h2);
    stop_stamp = start_stamp;
    step(3);
    chk({window_err, running, intr_closed}, 3'h5);
    stop_stamp = 27'h0000200;
    $display("test window done");
    now_stamp = 27'h0000150;
    on_ms = 10'(200 + $urandom % 601);
    cycle_chk(int'(on_ms) * 10, (1000 - int'(on_ms)) * 10);
    ms_range = 1'b0;
    cycle_chk(10000, 20000);
    $display("test internal done");
    summarize();
  end
  initial begin
    #950_000;
    err_count++;
    summarize();
  end
endmodule : tb_top
`default_nettype wire
